/* File: rtl/wpa_top.sv */
`timescale 1ns/10ps
// Wake-up phase and amplitude registers with averaging and interrupt
module wpa_top
	import wpa_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire wpa_bus_req_t busReq,
	output logic [7:0] busRdata,
	input wire wpa_meas_t phaseMeas,
	input wire wpa_meas_t ampMeas,
	input wire logic wakeupMode,
	input wire logic [2:0] calCode,
	output logic irq
);

	wpa_top_t st;
	wpa_top_t next_st;
	wpa_chan_t phChan;
	wpa_chan_t ampChan;
	logic [IRQ_W-1:0] events;

	// Phase channel
	wpa_channel u_phase (
		.clk(clk),
		.reset(reset),
		.meas(phaseMeas),
		.cfg(st.phCfg),
		.refValue(st.phRef),
		.wakeupMode(wakeupMode),
		.chanOut(phChan)
	);

	// Amplitude channel, same structure with its own config
	wpa_channel u_amp (
		.clk(clk),
		.reset(reset),
		.meas(ampMeas),
		.cfg(st.ampCfg),
		.refValue(st.ampRef),
		.wakeupMode(wakeupMode),
		.chanOut(ampChan)
	);

	// Event vector in status bit order
	always_comb begin
		events = '0;
		events[IRQ_PH_WAKE] = phChan.trig;
		events[IRQ_AMP_WAKE] = ampChan.trig;
		events[IRQ_PH_DONE] = phaseMeas.done;
		events[IRQ_AMP_DONE] = ampMeas.done;
	end

	// Register writes, status update and read mux
	always_comb begin
		next_st = st;
		// Calibration code is sampled every cycle for a stable readout
		next_st.cal = calCode;
		if (busReq.wr) begin
			case (busReq.addr)
				OFS_PH_CFG: begin
					next_st.phCfg = wpa_cfg_t'(busReq.wdata);
				end
				OFS_PH_REF: begin
					next_st.phRef = busReq.wdata;
				end
				OFS_AMP_CFG: begin
					next_st.ampCfg = wpa_cfg_t'(busReq.wdata);
				end
				OFS_AMP_REF: begin
					next_st.ampRef = busReq.wdata;
				end
				OFS_IRQ_STAT: begin
					next_st.irqStatus = st.irqStatus
						& ~busReq.wdata[IRQ_W-1:0];
				end
				OFS_IRQ_MASK: begin
					next_st.irqMask = busReq.wdata[IRQ_W-1:0];
				end
				default: begin
					// Read-only and unmapped addresses ignore writes
					next_st.irqMask = st.irqMask;
				end
			endcase
		end
		// Set wins over a clear arriving in the same cycle
		next_st.irqStatus = next_st.irqStatus | events;
		next_st.irq = |(next_st.irqStatus & next_st.irqMask);
		// Read data stands for exactly one cycle after the strobe
		next_st.rdata = REG_RESET;
		if (busReq.rd) begin
			case (busReq.addr)
				OFS_AMP_CFG: begin
					next_st.rdata = st.ampCfg;
				end
				OFS_AMP_REF: begin
					next_st.rdata = st.ampRef;
				end
				OFS_AMP_AVG: begin
					next_st.rdata = ampChan.avg;
				end
				OFS_AMP_RES: begin
					next_st.rdata = ampChan.last;
				end
				OFS_PH_CFG: begin
					next_st.rdata = st.phCfg;
				end
				OFS_PH_REF: begin
					next_st.rdata = st.phRef;
				end
				OFS_PH_AVG: begin
					next_st.rdata = phChan.avg;
				end
				OFS_PH_RES: begin
					next_st.rdata = phChan.last;
				end
				OFS_CAL: begin
					// Upper bits read zero; software must not rely on them
					next_st.rdata = {5'h00, st.cal};
				end
				OFS_IRQ_STAT: begin
					next_st.rdata = {4'h0, st.irqStatus};
				end
				OFS_IRQ_MASK: begin
					next_st.rdata = {4'h0, st.irqMask};
				end
				default: begin
					next_st.rdata = REG_RESET;
				end
			endcase
		end
	end

	// State register, constants only under reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st.phCfg <= wpa_cfg_t'(REG_RESET);
			st.phRef <= REG_RESET;
			st.ampCfg <= wpa_cfg_t'(REG_RESET);
			st.ampRef <= REG_RESET;
			st.cal <= CAL_RESET;
			st.irqStatus <= '0;
			st.irqMask <= '0;
			st.rdata <= REG_RESET;
			st.irq <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flip-flops
	assign busRdata = st.rdata;
	assign irq = st.irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Reference write lands and reads back
	sequence s_ref_write;
		busReq.wr && busReq.addr == OFS_PH_REF;
	endsequence
	sequence s_ref_read;
		busReq.rd && busReq.addr == OFS_PH_REF && !busReq.wr;
	endsequence
	property p_ref_write;
		s_ref_write ##1 s_ref_read
		|=> busRdata == $past(busReq.wdata, 2);
	endproperty
	a_ref_write: assert property (p_ref_write)
		else $error("phase reference did not read back");

	// Writing the average address leaves the average untouched
	property p_avg_ro;
		busReq.wr && busReq.addr == OFS_PH_AVG && !phaseMeas.done
		|=> phChan.avg == $past(phChan.avg);
	endproperty
	a_avg_ro: assert property (p_avg_ro)
		else $error("write changed phase average");

	// Calibration readout shows the code in the low three bits only
	property p_cal;
		busReq.rd && busReq.addr == OFS_CAL
		|=> busRdata[7:3] == 5'h00 && busRdata[2:0] == $past(st.cal);
	endproperty
	a_cal: assert property (p_cal)
		else $error("calibration readout wrong");

	// Amplitude average readout
	property p_amp_avg;
		busReq.rd && busReq.addr == OFS_AMP_AVG
		|=> busRdata == $past(ampChan.avg);
	endproperty
	a_amp_avg: assert property (p_amp_avg)
		else $error("amplitude average readout wrong");

	// Amplitude result captured and then readable
	property p_amp_res;
		ampMeas.done ##1 (busReq.rd && busReq.addr == OFS_AMP_RES)
		|=> busRdata == $past(ampMeas.value, 2);
	endproperty
	a_amp_res: assert property (p_amp_res)
		else $error("amplitude result readout wrong");

	// Average as reference: a sample equal to it never trips
	property p_amp_sel;
		ampMeas.done && st.ampCfg.refSelect && ampMeas.value == ampChan.avg
		|=> !ampChan.trig;
	endproperty
	a_amp_sel: assert property (p_amp_sel)
		else $error("amplitude tripped on its own average");

	// Register as reference: a sample equal to it never trips
	property p_ph_sel;
		phaseMeas.done && !st.phCfg.refSelect && phaseMeas.value == st.phRef
		|=> !phChan.trig;
	endproperty
	a_ph_sel: assert property (p_ph_sel)
		else $error("phase tripped on its own reference");

	// Unmasked phase wake-up raises the interrupt the next cycle
	sequence s_ph_wake;
		phChan.trig && st.irqMask[IRQ_PH_WAKE]
			&& !(busReq.wr && busReq.addr == OFS_IRQ_MASK);
	endsequence
	sequence s_irq_up;
		irq && st.irqStatus[IRQ_PH_WAKE];
	endsequence
	property p_wake_irq;
		s_ph_wake |=> s_irq_up;
	endproperty
	a_wake_irq: assert property (p_wake_irq)
		else $error("phase wake-up did not raise interrupt");

	// Write-one clears a status bit when no new event arrives
	property p_clear;
		busReq.wr && busReq.addr == OFS_IRQ_STAT
			&& busReq.wdata[IRQ_PH_WAKE] && !phChan.trig
		|=> !st.irqStatus[IRQ_PH_WAKE];
	endproperty
	a_clear: assert property (p_clear)
		else $error("status bit not cleared");

	// Read data stands only in the cycle after the strobe
	property p_rd_idle;
		!busReq.rd |=> busRdata == REG_RESET;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data held beyond one cycle");

	// A done pulse marks its status bit even when a clear meets it
	property p_ph_done;
		phaseMeas.done |=> st.irqStatus[IRQ_PH_DONE];
	endproperty
	a_ph_done: assert property (p_ph_done)
		else $error("phase done status not set");

	// Same for the amplitude channel
	property p_amp_done;
		ampMeas.done |=> st.irqStatus[IRQ_AMP_DONE];
	endproperty
	a_amp_done: assert property (p_amp_done)
		else $error("amplitude done status not set");

	// Amplitude wake-up trigger always reaches its status bit
	property p_amp_wake;
		ampChan.trig |=> st.irqStatus[IRQ_AMP_WAKE];
	endproperty
	a_amp_wake: assert property (p_amp_wake)
		else $error("amplitude wake-up status not set");

	// Status stays set until software writes a one to it
	property p_sticky;
		st.irqStatus[IRQ_PH_WAKE]
			&& !(busReq.wr && busReq.addr == OFS_IRQ_STAT)
		|=> st.irqStatus[IRQ_PH_WAKE];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("phase wake-up status dropped on its own");

	// Mask register takes the low bits of a write
	property p_mask_wr;
		busReq.wr && busReq.addr == OFS_IRQ_MASK
		|=> st.irqMask == $past(busReq.wdata[IRQ_W-1:0]);
	endproperty
	a_mask_wr: assert property (p_mask_wr)
		else $error("mask write did not land");

	// Phase configuration holds exactly the byte last written
	property p_ph_cfg;
		busReq.wr && busReq.addr == OFS_PH_CFG
		|=> st.phCfg == $past(busReq.wdata);
	endproperty
	a_ph_cfg: assert property (p_ph_cfg)
		else $error("phase configuration write did not land");

	// Amplitude configuration holds exactly the byte last written
	property p_amp_cfg;
		busReq.wr && busReq.addr == OFS_AMP_CFG
		|=> st.ampCfg == $past(busReq.wdata);
	endproperty
	a_amp_cfg: assert property (p_amp_cfg)
		else $error("amplitude configuration write did not land");

	// Phase reference readout shows the stored byte
	property p_ph_ref;
		busReq.rd && busReq.addr == OFS_PH_REF
		|=> busRdata == $past(st.phRef);
	endproperty
	a_ph_ref: assert property (p_ph_ref)
		else $error("phase reference readout wrong");

	// Phase average readout shows the running average
	property p_ph_avg;
		busReq.rd && busReq.addr == OFS_PH_AVG
		|=> busRdata == $past(phChan.avg);
	endproperty
	a_ph_avg: assert property (p_ph_avg)
		else $error("phase average readout wrong");

	// Phase result captured, then read in the very next cycle
	sequence s_ph_done;
		phaseMeas.done;
	endsequence
	sequence s_ph_res_rd;
		busReq.rd && busReq.addr == OFS_PH_RES;
	endsequence
	property p_ph_res;
		s_ph_done ##1 s_ph_res_rd
		|=> busRdata == $past(phaseMeas.value, 2);
	endproperty
	a_ph_res: assert property (p_ph_res)
		else $error("phase result readout wrong");

	// Writing the amplitude readouts leaves both untouched
	property p_amp_ro;
		busReq.wr && !ampMeas.done
			&& (busReq.addr == OFS_AMP_AVG || busReq.addr == OFS_AMP_RES)
		|=> ampChan.avg == $past(ampChan.avg)
			&& ampChan.last == $past(ampChan.last);
	endproperty
	a_amp_ro: assert property (p_amp_ro)
		else $error("write changed amplitude readout");

	// Clearing every status bit with no new event drops the interrupt
	property p_irq_drop;
		busReq.wr && busReq.addr == OFS_IRQ_STAT
			&& busReq.wdata[IRQ_W-1:0] == '1 && events == '0
		|=> !irq;
	endproperty
	a_irq_drop: assert property (p_irq_drop)
		else $error("interrupt stayed up after full clear");

	// With everything masked, pending status never raises the interrupt
	property p_masked;
		st.irqMask == '0
			&& !(busReq.wr && busReq.addr == OFS_IRQ_MASK)
		|=> !irq;
	endproperty
	a_masked: assert property (p_masked)
		else $error("interrupt raised while fully masked");

endmodule // wpa_top

/* File: include/wpa_pkg.sv */
package wpa_pkg;

	// Register offsets; bit 7 of the address selects register space B
	localparam logic [7:0] OFS_AMP_CFG = 8'h33;
	localparam logic [7:0] OFS_AMP_REF = 8'h34;
	localparam logic [7:0] OFS_AMP_AVG = 8'h35;
	localparam logic [7:0] OFS_AMP_RES = 8'h36;
	localparam logic [7:0] OFS_PH_CFG = 8'h37;
	localparam logic [7:0] OFS_PH_REF = 8'h38;
	localparam logic [7:0] OFS_PH_AVG = 8'h39;
	localparam logic [7:0] OFS_PH_RES = 8'h3A;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h3C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h3D;
	localparam logic [7:0] OFS_CAL = 8'hB9;

	// Reset values and the calibration centre code
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [2:0] CAL_RESET = 3'h0;
	localparam logic [2:0] CAL_CENTRE = 3'h3;

	// Smallest averaging weight is 4, a shift of two
	localparam logic [2:0] AVG_SHIFT_BASE = 3'h2;

	// Interrupt status and mask bit positions
	localparam int IRQ_W = 4;
	localparam int IRQ_PH_WAKE = 0;
	localparam int IRQ_AMP_WAKE = 1;
	localparam int IRQ_PH_DONE = 2;
	localparam int IRQ_AMP_DONE = 3;

	// Wake-up configuration byte, bit 7 down to bit 0
	typedef struct packed {
		logic [3:0] threshold;
		logic includeTrigger;
		logic [1:0] weight;
		logic refSelect;
	} wpa_cfg_t;

	// One register access from the host port
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wpa_bus_req_t;

	// A completed measurement from the analog front end
	typedef struct packed {
		logic done;
		logic [7:0] value;
	} wpa_meas_t;

	// State of one measurement channel
	typedef struct packed {
		logic [7:0] avg;
		logic [7:0] last;
		logic trig;
	} wpa_chan_t;

	// State of the register block
	typedef struct packed {
		wpa_cfg_t phCfg;
		logic [7:0] phRef;
		wpa_cfg_t ampCfg;
		logic [7:0] ampRef;
		logic [2:0] cal;
		logic [IRQ_W-1:0] irqStatus;
		logic [IRQ_W-1:0] irqMask;
		logic [7:0] rdata;
		logic irq;
	} wpa_top_t;

endpackage

/* File: rtl/wpa_channel.sv */
`timescale 1ns/10ps
// One measurement channel: compare against reference, keep running average
module wpa_channel
	import wpa_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire wpa_meas_t meas,
	input wire wpa_cfg_t cfg,
	input wire logic [7:0] refValue,
	input wire logic wakeupMode,
	output wpa_chan_t chanOut
);

	wpa_chan_t st;
	wpa_chan_t next_st;
	logic [7:0] reference;
	logic [7:0] gap;
	logic tripped;
	logic [2:0] shift;
	logic signed [9:0] delta;
	logic signed [9:0] step;

	// Compare, then fold into average; with refSelect set the old average is the reference
	always_comb begin
		next_st = st;
		reference = cfg.refSelect ? st.avg : refValue;
		gap = (meas.value >= reference) ? meas.value - reference
			: reference - meas.value;
		tripped = wakeupMode && meas.done
			&& (gap > {4'h0, cfg.threshold});
		shift = AVG_SHIFT_BASE + {1'b0, cfg.weight};
		delta = $signed({2'b00, meas.value}) - $signed({2'b00, st.avg});
		// Arithmetic shift floors, so a rising average settles low; a falling one reaches the input
		step = delta >>> shift;
		next_st.trig = tripped;
		if (meas.done) begin
			next_st.last = meas.value;
			if (!tripped || cfg.includeTrigger) begin
				next_st.avg = st.avg + step[7:0];
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign chanOut = st;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// A sample exactly on the average never moves it
	property p_avg_still;
		meas.done && meas.value == st.avg |=> st.avg == $past(st.avg);
	endproperty
	a_avg_still: assert property (p_avg_still)
		else $error("average moved on equal sample");

	// Weight 32 limits one step to at most seven counts upward
	property p_weight_step;
		meas.done && !tripped && cfg.weight == 2'b11
			&& meas.value > st.avg
		|=> st.avg >= $past(st.avg) && st.avg - $past(st.avg) <= 8'h07;
	endproperty
	a_weight_step: assert property (p_weight_step)
		else $error("average step too large for weight 32");

	// Excluded trigger sample leaves the average alone
	property p_exclude;
		meas.done && tripped && !cfg.includeTrigger
		|=> st.avg == $past(st.avg) && st.trig;
	endproperty
	a_exclude: assert property (p_exclude)
		else $error("excluded sample changed average");

	// Result register follows every completed measurement
	property p_last;
		meas.done |=> st.last == $past(meas.value);
	endproperty
	a_last: assert property (p_last)
		else $error("result not captured");

	// Gap above threshold in wake-up mode flags a trigger next cycle
	property p_trip;
		wakeupMode && meas.done && gap > {4'h0, cfg.threshold} |=> st.trig;
	endproperty
	a_trip: assert property (p_trip)
		else $error("missed wake-up trigger");

	// No trigger outside wake-up mode
	property p_no_trip;
		!wakeupMode |=> !st.trig;
	endproperty
	a_no_trip: assert property (p_no_trip)
		else $error("trigger outside wake-up mode");

endmodule // wpa_channel

/* File: testbench/wpa_top_tb_top.sv */
`timescale 1ns/10ps
// Self-checking bench for the wake-up phase and amplitude register block
module wpa_top_tb_top;
	import wpa_pkg::*;

	logic clk;
	logic reset;
	wpa_bus_req_t busReq;
	logic [7:0] busRdata;
	wpa_meas_t phaseMeas;
	wpa_meas_t ampMeas;
	logic wakeupMode;
	logic [2:0] calCode;
	logic irq;
	int num_errors;
	int compares;
	logic [7:0] phAvg;
	logic [7:0] ampAvg;

	wpa_top i_wpa_top (
		.clk(clk),
		.reset(reset),
		.busReq(busReq),
		.busRdata(busRdata),
		.phaseMeas(phaseMeas),
		.ampMeas(ampMeas),
		.wakeupMode(wakeupMode),
		.calCode(calCode),
		.irq(irq)
	);

	// Free-running 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Byte compare, every design value checked with case equality
	task automatic chk(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Interrupt level, sampled once the launching edge has settled
	task automatic chk_irq(input logic exp);
		#1;
		chk("irq", {7'h00, exp}, {7'h00, irq});
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		busReq <= '{1'b1, 1'b0, addr, data};
		@(posedge clk);
		busReq <= '0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rdchk(input string name, input logic [7:0] addr,
		input logic [7:0] exp);
		@(posedge clk);
		busReq <= '{1'b0, 1'b1, addr, 8'h00};
		@(posedge clk);
		busReq <= '0;
		#1;
		chk(name, exp, busRdata);
	endtask

	// One measurement pulse, then room for the wake-up status to land
	task automatic meas(input logic isAmp, input logic [7:0] v);
		@(posedge clk);
		if (isAmp) ampMeas <= '{1'b1, v};
		else phaseMeas <= '{1'b1, v};
		@(posedge clk);
		ampMeas <= '0;
		phaseMeas <= '0;
		repeat (2) @(posedge clk);
	endtask

	// Floor of the signed difference over the weight
	function automatic logic [7:0] avg_next(input logic [7:0] a,
		input logic [7:0] v, input logic [1:0] w);
		logic signed [9:0] d;
		d = $signed({2'b00, v}) - $signed({2'b00, a});
		d = d >>> (2 + w);
		return a + d[7:0];
	endfunction

	// Every register but amplitude config and reference is checked to read zero out of reset
	task automatic test_reset();
		logic [7:0] ofs [9];
		ofs = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3C, 8'h3D,
			8'hB9};
		foreach (ofs[i])
			rdchk("reset value", ofs[i], 8'h00);
		chk_irq(1'b0);
		$display("test_reset done");
	endtask

	// Writable reference, read-only places and an unmapped hole
	task automatic test_regs();
		logic [7:0] ro [5];
		ro = '{8'h35, 8'h36, 8'h39, 8'h3A, 8'hB9};
		wr(8'h38, 8'hA5);
		rdchk("phase ref", 8'h38, 8'hA5);
		foreach (ro[i]) begin
			wr(ro[i], 8'hFF);
			rdchk("read-only", ro[i], 8'h00);
		end
		rdchk("unmapped", 8'h3E, 8'h00);
		wr(8'h38, 8'h00);
		$display("test_regs done");
	endtask

	// Calibration code shows in the low bits only, centre included
	task automatic test_cal();
		calCode <= CAL_CENTRE;
		rdchk("cal centre", 8'hB9, 8'h03);
		calCode <= 3'h7;
		rdchk("cal top", 8'hB9, 8'h07);
		$display("test_cal done");
	endtask

	// Averages for all four weights, rising and falling inputs
	task automatic test_avg();
		logic [7:0] vals [2];
		vals = '{8'hC8, 8'h11};
		wakeupMode <= 1'b0;
		for (int w = 0; w < 4; w++) begin
			wr(8'h37, {5'h00, w[1:0], 1'b0});
			wr(8'h33, {5'h00, w[1:0], 1'b0});
			foreach (vals[i]) begin
				meas(1'b0, vals[i]);
				phAvg = avg_next(phAvg, vals[i], w[1:0]);
				rdchk("phase result", 8'h3A, vals[i]);
				rdchk("phase avg", 8'h39, phAvg);
				meas(1'b1, vals[i] ^ 8'h5A);
				ampAvg = avg_next(ampAvg, vals[i] ^ 8'h5A, w[1:0]);
				rdchk("amp result", 8'h36, vals[i] ^ 8'h5A);
				rdchk("amp avg", 8'h35, ampAvg);
			end
		end
		$display("test_avg done");
	endtask

	// Fixed reference: threshold edge and the include bit
	task automatic test_wake();
		wakeupMode <= 1'b1;
		wr(8'h3C, 8'h0F);
		wr(8'h3D, 8'h01);
		wr(8'h38, 8'h40);
		wr(8'h37, 8'h20);
		rdchk("phase cfg", 8'h37, 8'h20);
		rdchk("irq mask", 8'h3D, 8'h01);
		meas(1'b0, 8'h42);
		chk_irq(1'b0);
		phAvg = avg_next(phAvg, 8'h42, 2'b00);
		// A sample equal to the reference register must not trip
		meas(1'b0, 8'h40);
		chk_irq(1'b0);
		phAvg = avg_next(phAvg, 8'h40, 2'b00);
		meas(1'b0, 8'h3D);
		chk_irq(1'b1);
		rdchk("phase avg skip", 8'h39, phAvg);
		rdchk("status", 8'h3C, 8'h05);
		wr(8'h3C, 8'h05);
		chk_irq(1'b0);
		// Include the tripping sample this time
		wr(8'h37, 8'h28);
		meas(1'b0, 8'h50);
		chk_irq(1'b1);
		phAvg = avg_next(phAvg, 8'h50, 2'b00);
		rdchk("phase avg incl", 8'h39, phAvg);
		wr(8'h3C, 8'h0F);
		$display("test_wake done");
	endtask

	// Average as reference; register placed far off so only it would trip
	task automatic test_select(input logic isAmp);
		logic [7:0] a;
		logic [7:0] base;
		base = isAmp ? 8'h33 : 8'h37;
		a = isAmp ? ampAvg : phAvg;
		wr(8'h3C, 8'h0F);
		wr(8'h3D, isAmp ? 8'h02 : 8'h01);
		wr(base + 8'h01, a + 8'h80);
		wr(base, 8'h21);
		rdchk("cfg", base, 8'h21);
		rdchk("ref", base + 8'h01, a + 8'h80);
		meas(isAmp, a + 8'h02);
		chk_irq(1'b0);
		a = avg_next(a, a + 8'h02, 2'b00);
		meas(isAmp, a + 8'h03);
		chk_irq(1'b1);
		rdchk("avg after trip", base + 8'h02, a);
		wr(8'h3C, 8'h0F);
		chk_irq(1'b0);
		if (isAmp) ampAvg = a;
		else phAvg = a;
		$display("test_select done");
	endtask

	// Strobes with no gap, a read right after a result, a set on its clear
	task automatic test_b2b();
		@(posedge clk);
		busReq <= '{1'b1, 1'b0, 8'h38, 8'h5C};
		@(posedge clk);
		busReq <= '{1'b0, 1'b1, 8'h38, 8'h00};
		ampMeas <= '{1'b1, ampAvg};
		@(posedge clk);
		busReq <= '{1'b0, 1'b1, 8'h36, 8'h00};
		ampMeas <= '0;
		phaseMeas <= '{1'b1, phAvg};
		#1;
		chk("ref b2b", 8'h5C, busRdata);
		@(posedge clk);
		busReq <= '{1'b0, 1'b1, 8'h3A, 8'h00};
		phaseMeas <= '0;
		#1;
		chk("amp result b2b", ampAvg, busRdata);
		@(posedge clk);
		busReq <= '{1'b1, 1'b0, 8'h3C, 8'h04};
		phaseMeas <= '{1'b1, phAvg};
		#1;
		chk("phase result b2b", phAvg, busRdata);
		@(posedge clk);
		busReq <= '{1'b0, 1'b1, 8'h3C, 8'h00};
		phaseMeas <= '0;
		@(posedge clk);
		busReq <= '0;
		#1;
		chk("status set wins", 8'h0C, busRdata);
		$display("test_b2b done");
	endtask

	// Single exit for both the normal end and the watchdog
	task automatic end_sim();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		num_errors = 0;
		compares = 0;
		phAvg = 8'h00;
		ampAvg = 8'h00;
		reset = 1'b1;
		busReq = '0;
		phaseMeas = '0;
		ampMeas = '0;
		wakeupMode = 1'b0;
		calCode = 3'h0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		test_reset();
		test_regs();
		test_cal();
		test_avg();
		test_wake();
		test_select(1'b0);
		test_select(1'b1);
		test_b2b();
		// Mid-run reset must bring every register but amplitude config and reference back to zero
		calCode <= 3'h0;
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		test_reset();
		end_sim();
	end

	// Watchdog: the whole run needs well under this span
	initial begin
		#200000;
		num_errors++;
		end_sim();
	end

endmodule // wpa_top_tb_top
